// ### src/tcpd_port.sv
// type-c port attach detection, role swap, dead battery and charger advert
// Functional notes
// [R1] source role: pull-up on both pins
// [R2] source role: low pin flags sink attach
// [R3] four advertisement levels select thresholds
// [R4] below cable threshold means active cable
// [R5] rising above detach threshold ends connection
// [R6] sink role: trimmed pull-down, await source
// [R7] sink attach only with vbus present; the swap state still enters sink attach without checking vbus
// [R8] sink decodes partner current from pull-up
// [R9] dual role toggles pull-down and pull-up
// [R10] sink swap detect flags, then source
// [R11] source swap request, then sink
// [R12] dead battery pull-down, later trimmed
// [R13] control removes dead battery pull-down
// [R14] bus power conversion selects start-up
// [R15] external supply boot: path a port1, b port2
// [R16] contact detect: d+ source, d- pull-down
// [R17] primary/secondary: drive voltage, sink, sample
// [R18] cdp: mirror 0.6v on d- while d+ high
// [R19] dcp: short d+ to d- via resistor
// [R20] divider mode: drive both lines
// [R21] open pins: vbus and vconn off
// [R22] cable plus sink: vconn on cable pin
// [R23] comparator outputs synchronised first
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module tcpd_port #(
  parameter int DRP_HALF = tcpd_pkg::DRP_HALF_CYC,
  parameter logic [31:0] BLOCK_ID = 32'h0000_5a5a
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cc comparators per pin: below detach/sink threshold, below cable threshold, below swap threshold
  input wire logic [1:0] cc_below_sink,
  input wire logic [1:0] cc_below_cable,
  input wire logic [1:0] cc_below_swap,
  // sink side partner advertisement comparators: above 1.5a and 3a levels
  input wire logic [1:0] cc_above_1p5,
  input wire logic [1:0] cc_above_3p0,
  input wire logic vbus_present,
  // data-line comparators
  input wire logic dplus_above_0p6,
  input wire logic dline_sample_hi,
  // bus power conversion result, valid pulse
  input wire logic [7:0] boot_code,
  input wire logic boot_code_valid,
  // cc front-end controls
  output logic [1:0] cc_pullup_current,
  output logic [1:0] adv_level,
  output logic [1:0] trimmed_sink_pulldown,
  output logic dead_battery_pulldown,
  output logic [1:0] swap_signal_pulldown,
  output logic vbus_src_en,
  output logic [1:0] vconn_en,
  output logic swap_event,
  // boot outputs
  output logic ext_path_ctrl_a,
  output logic ext_path_ctrl_b,
  // data-line front-end controls
  output logic dplus_source_current,
  output logic dminus_pulldown,
  output logic [1:0] data_line_voltage_source,
  output logic [1:0] data_line_current_sink,
  output logic data_short_resistor,
  output logic divider_drive,
  output logic converter_sample
);
  typedef enum logic [2:0] {ST_UNATT, ST_SRC_ATT, ST_SNK_WAIT, ST_SNK_ATT, ST_SWAP_SRC} tcpd_st_t;

  logic [31:0] ctrl_q;
  logic [2:0] bc_q;
  logic [1:0] evt_q;
  logic [7:0] boot_q;
  logic boot_done_q;
  tcpd_st_t st_q;
  logic [1:0] mon_q;
  logic [1:0] cable_q;
  logic drp_src_q;
  logic db_q;
  logic cdp_q;
  logic [1:0] partner_adv_q;
  logic tick;
  logic [9:0] fe_s;
  logic [1:0] s_below_sink, s_below_cable, s_below_swap, s_above_1p5, s_above_3p0;
  logic s_vbus, s_dp06, s_dline;
  logic wr_en, rd_en;
  logic [1:0] role;
  logic [1:0] ra_pins, rd_pins;
  logic src_act;
  logic frs_en;
  logic src_detach;
  logic [1:0] settle_q;

  // front-end levels come from analog comparators, so they are synchronised
  tcpd_sync #(.W(10)) u_cc_sync ( // R23
    .mclk(mclk),
    .rst(rst),
    .d({cc_below_sink, cc_below_cable, cc_below_swap, cc_above_1p5, cc_above_3p0}),
    .q(fe_s)
  );
  tcpd_sync #(.W(3)) u_misc_sync ( // R23
    .mclk(mclk),
    .rst(rst),
    .d({vbus_present, dplus_above_0p6, dline_sample_hi}),
    .q({s_vbus, s_dp06, s_dline})
  );
  assign {s_below_sink, s_below_cable, s_below_swap, s_above_1p5, s_above_3p0} = fe_s;

  tcpd_tick #(.N(DRP_HALF)) u_drp_tick (
    .mclk(mclk),
    .rst(rst),
    .tick(tick)
  );

  // apb: zero wait states, unmapped addresses answer with slverr
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign role = ctrl_q[tcpd_pkg::CTRL_ROLE_LSB +: 2];
  assign frs_en = ctrl_q[tcpd_pkg::CTRL_FRS_EN];

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == tcpd_pkg::OFF_CTRL) || (a == tcpd_pkg::OFF_BC) || (a == tcpd_pkg::OFF_STAT) ||
      (a == tcpd_pkg::OFF_EVT) || (a == tcpd_pkg::OFF_BOOT) || (a == tcpd_pkg::OFF_ID);
  endfunction

  assign pslverr = psel && penable && !mapped(paddr);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= tcpd_pkg::CTRL_RST;
    end
    else if (wr_en && paddr == tcpd_pkg::OFF_CTRL)
    begin
      ctrl_q <= {23'h0, pwdata[8:0]};
    end
    else if (st_q == ST_SRC_ATT && ctrl_q[tcpd_pkg::CTRL_FRS_REQ] && frs_en)
    begin
      // swap request is one-shot; the signalling state holds the pull-down
      ctrl_q[tcpd_pkg::CTRL_FRS_REQ] <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bc_q <= tcpd_pkg::BC_RST[2:0];
    end
    else if (wr_en && paddr == tcpd_pkg::OFF_BC)
    begin
      bc_q <= pwdata[2:0];
    end
  end

  // sticky events: bit0 source detach, bit1 swap; set beats write-one-clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      evt_q <= 2'b00;
    end
    else
    begin
      evt_q <= (evt_q & ~((wr_en && paddr == tcpd_pkg::OFF_EVT) ? pwdata[1:0] : 2'b00)) |
        {swap_event, src_detach};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      if (paddr == tcpd_pkg::OFF_CTRL)
        prdata <= ctrl_q;
      else if (paddr == tcpd_pkg::OFF_BC)
        prdata <= {29'h0, bc_q};
      else if (paddr == tcpd_pkg::OFF_STAT)
        prdata <= {20'h0, s_dline, db_q, cdp_q, partner_adv_q, cable_q, mon_q, st_q}; // R17
      else if (paddr == tcpd_pkg::OFF_EVT)
        prdata <= {30'h0, evt_q};
      else if (paddr == tcpd_pkg::OFF_BOOT)
        prdata <= {23'h0, boot_done_q, boot_q};
      else if (paddr == tcpd_pkg::OFF_ID)
        prdata <= BLOCK_ID;
      else
        prdata <= 32'h0000_0000;
    end
  end

  // sample the bus power conversion once after reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      boot_q <= 8'h00;
      boot_done_q <= 1'b0;
    end
    else if (boot_code_valid && !boot_done_q)
    begin
      boot_q <= boot_code; // R14
      boot_done_q <= 1'b1;
    end
  end

  // external-supply boot: path a serves port 1, path b port 2
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_path_ctrl_a <= 1'b0;
      ext_path_ctrl_b <= 1'b0;
    end
    else
    begin
      ext_path_ctrl_a <= boot_done_q && boot_q >= tcpd_pkg::BOOT_EXT_CODE && ctrl_q[tcpd_pkg::CTRL_BOOT_EXT]; // R14 R15
      ext_path_ctrl_b <= boot_done_q && boot_q >= tcpd_pkg::BOOT_EXT_CODE && !ctrl_q[tcpd_pkg::CTRL_BOOT_EXT]; // R15
    end
  end

  // ra = below cable threshold; rd = below sink threshold only
  assign ra_pins = s_below_cable; // R4
  assign rd_pins = s_below_sink & ~s_below_cable; // R2 R3
  assign src_act = (role == tcpd_pkg::ROLE_SRC) || (role == tcpd_pkg::ROLE_DRP && drp_src_q);

  assign src_detach = st_q == ST_SRC_ATT && (mon_q & ~s_below_sink) != 2'b00; // R5

  // an open pin reads low until the pull-up has passed both sync stages; wait that out
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      settle_q <= 2'b00;
    else if (cc_pullup_current != 2'b11)
      settle_q <= 2'b00;
    else if (settle_q != 2'b11)
      settle_q <= settle_q + 2'b01;
  end

  // dual-role toggling while no partner is attached
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      drp_src_q <= 1'b0;
    else if (role == tcpd_pkg::ROLE_DRP && (st_q == ST_UNATT || st_q == ST_SNK_WAIT) && tick)
      drp_src_q <= !drp_src_q; // R9
  end

  // attach state machine
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_UNATT;
      mon_q <= 2'b00;
      cable_q <= 2'b00;
    end
    else
    begin
      case (st_q)
        ST_UNATT:
        begin
          cable_q <= ra_pins;
          if (src_act && settle_q == 2'b11 && rd_pins != 2'b00) // R21
          begin
            st_q <= ST_SRC_ATT; // R2
            mon_q <= rd_pins; // R22
          end
          else if (!src_act && role != tcpd_pkg::ROLE_OFF)
            st_q <= ST_SNK_WAIT; // R6
        end
        ST_SNK_WAIT:
        begin
          if (src_act || role == tcpd_pkg::ROLE_OFF)
            st_q <= ST_UNATT;
          else if (s_vbus)
          begin
            st_q <= ST_SNK_ATT; // R7
            mon_q <= 2'b11;
          end
        end
        ST_SRC_ATT:
        begin
          if ((mon_q & ~s_below_sink) != 2'b00)
          begin
            st_q <= ST_UNATT; // R5
            mon_q <= 2'b00;
          end
          else if (frs_en && ctrl_q[tcpd_pkg::CTRL_FRS_REQ])
            st_q <= ST_SWAP_SRC; // R11
        end
        ST_SWAP_SRC:
          st_q <= ST_SNK_ATT; // R11
        ST_SNK_ATT:
        begin
          if (!s_vbus)
          begin
            st_q <= ST_UNATT;
            mon_q <= 2'b00;
          end
          else if (frs_en && s_below_swap != 2'b00)
          begin
            st_q <= ST_SRC_ATT; // R10
            mon_q <= s_below_swap;
          end
        end
        default:
          st_q <= ST_UNATT;
      endcase
    end
  end

  assign swap_event = st_q == ST_SNK_ATT && s_vbus && frs_en && s_below_swap != 2'b00; // R10

  // partner current decode while sinking
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      partner_adv_q <= 2'b00;
    else if (st_q == ST_SNK_ATT)
      partner_adv_q <= (s_above_3p0 != 2'b00) ? 2'd3 : (s_above_1p5 != 2'b00) ? 2'd2 : 2'd0; // R8
  end

  // dead battery pull-down until released or trimmed
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      db_q <= 1'b1; // R12
    else if (ctrl_q[tcpd_pkg::CTRL_DB_REL] || ctrl_q[tcpd_pkg::CTRL_TRIM])
      db_q <= 1'b0; // R12 R13
  end

  // cc pin controls from flops
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cc_pullup_current <= 2'b00;
      trimmed_sink_pulldown <= 2'b00;
      dead_battery_pulldown <= 1'b0;
      swap_signal_pulldown <= 2'b00;
      vbus_src_en <= 1'b0;
      vconn_en <= 2'b00;
      adv_level <= 2'b00;
    end
    else
    begin
      adv_level <= ctrl_q[tcpd_pkg::CTRL_ADV_LSB +: 2]; // R3
      cc_pullup_current <= (src_act && st_q == ST_UNATT) || st_q == ST_SRC_ATT ? 2'b11 : 2'b00; // R1 R9
      trimmed_sink_pulldown <= (!src_act && st_q != ST_SRC_ATT && role != tcpd_pkg::ROLE_OFF && !db_q) ||
        st_q == ST_SNK_ATT ? 2'b11 : 2'b00; // R6
      dead_battery_pulldown <= db_q; // R12
      swap_signal_pulldown <= st_q == ST_SWAP_SRC ? mon_q : 2'b00; // R11
      vbus_src_en <= st_q == ST_SRC_ATT; // R21
      vconn_en <= st_q == ST_SRC_ATT ? (cable_q & ~mon_q) : 2'b00; // R21 R22
    end
  end

  // cdp mirror: hold d- drive while d+ stays at 0.6 v
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cdp_q <= 1'b0;
    else
      cdp_q <= bc_q == tcpd_pkg::BC_CDP && s_dp06; // R18
  end

  // data-line controls
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dplus_source_current <= 1'b0;
      dminus_pulldown <= 1'b0;
      data_line_voltage_source <= 2'b00;
      data_line_current_sink <= 2'b00;
      data_short_resistor <= 1'b0;
      divider_drive <= 1'b0;
      converter_sample <= 1'b0;
    end
    else
    begin
      dplus_source_current <= bc_q == tcpd_pkg::BC_DCD; // R16
      dminus_pulldown <= bc_q == tcpd_pkg::BC_DCD; // R16
      // bit0 = d+, bit1 = d-; secondary swaps the lines
      data_line_voltage_source <= bc_q == tcpd_pkg::BC_PRIM ? 2'b01 : bc_q == tcpd_pkg::BC_SEC ? 2'b10 :
        cdp_q ? 2'b10 : 2'b00; // R17 R18
      data_line_current_sink <= bc_q == tcpd_pkg::BC_PRIM ? 2'b10 : bc_q == tcpd_pkg::BC_SEC ? 2'b01 :
        bc_q == tcpd_pkg::BC_CDP ? 2'b01 : 2'b00; // R17
      converter_sample <= bc_q == tcpd_pkg::BC_PRIM || bc_q == tcpd_pkg::BC_SEC || bc_q == tcpd_pkg::BC_CDP; // R17
      data_short_resistor <= bc_q == tcpd_pkg::BC_DCP; // R19
      divider_drive <= bc_q == tcpd_pkg::BC_DIV; // R20
    end
  end

  // assertions
  property p_vbus_off_open;
    @(posedge mclk) disable iff (rst) (st_q == ST_UNATT) |=> !vbus_src_en;
  endproperty
  a_vbus_off_open: assert property (p_vbus_off_open) else $error("vbus on while unattached"); // R21

  property p_detach;
    @(posedge mclk) disable iff (rst) (st_q == ST_SRC_ATT && (mon_q & ~s_below_sink) != 2'b00) |=> st_q == ST_UNATT;
  endproperty
  a_detach: assert property (p_detach) else $error("detach not registered"); // R5

  property p_snk_vbus;
    @(posedge mclk) disable iff (rst) $rose(st_q == ST_SNK_ATT) && $past(st_q) == ST_SNK_WAIT |-> $past(s_vbus);
  endproperty
  a_snk_vbus: assert property (p_snk_vbus) else $error("sink attach without vbus"); // R7

  sequence s_swap_req;
    st_q == ST_SRC_ATT ##1 st_q == ST_SWAP_SRC;
  endsequence
  property p_swap_src;
    @(posedge mclk) disable iff (rst) s_swap_req |=> st_q == ST_SNK_ATT ##0 swap_signal_pulldown != 2'b00;
  endproperty
  a_swap_src: assert property (p_swap_src) else $error("swap signalling missing"); // R11

  property p_swap_evt;
    @(posedge mclk) disable iff (rst) swap_event |=> st_q == ST_SRC_ATT;
  endproperty
  a_swap_evt: assert property (p_swap_evt) else $error("swap did not start sourcing"); // R10

  property p_dcd;
    @(posedge mclk) disable iff (rst) dplus_source_current |-> dminus_pulldown && $past(bc_q) == tcpd_pkg::BC_DCD;
  endproperty
  a_dcd: assert property (p_dcd) else $error("contact detect drive wrong"); // R16

  property p_dcp;
    @(posedge mclk) disable iff (rst) bc_q == tcpd_pkg::BC_DCP ##1 bc_q == tcpd_pkg::BC_DCP |-> data_short_resistor;
  endproperty
  a_dcp: assert property (p_dcp) else $error("dcp short missing"); // R19

  property p_vconn;
    @(posedge mclk) disable iff (rst) (vconn_en & mon_q) == 2'b00 || !vbus_src_en;
  endproperty
  a_vconn: assert property (p_vconn) else $error("vconn on monitored pin"); // R22
endmodule

// ### src/tcpd_pkg.sv
// package for the type-c port detect and charger advertisement block
package tcpd_pkg;
  // current advertisement levels
  typedef enum logic [1:0] {ADV_DEF500, ADV_DEF900, ADV_1P5A, ADV_3P0A} tcpd_adv_t;
  // port role configuration
  typedef enum logic [1:0] {ROLE_SRC, ROLE_SNK, ROLE_DRP, ROLE_OFF} tcpd_role_t;
  // data-line charger modes
  typedef enum logic [2:0] {BC_IDLE, BC_DCD, BC_PRIM, BC_SEC, BC_CDP, BC_DCP, BC_DIV} tcpd_bc_t;
  // register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_BC = 12'h004;
  localparam logic [11:0] OFF_STAT = 12'h008;
  localparam logic [11:0] OFF_EVT = 12'h00c;
  localparam logic [11:0] OFF_BOOT = 12'h010;
  localparam logic [11:0] OFF_ID = 12'h014;
  // control field positions
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_ADV_LSB = 2;
  localparam int CTRL_FRS_EN = 4;
  localparam int CTRL_FRS_REQ = 5;
  localparam int CTRL_DB_REL = 6;
  localparam int CTRL_TRIM = 7;
  localparam int CTRL_BOOT_EXT = 8;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] BC_RST = 32'h0000_0000;
  // dual-role toggle half period
  localparam int DRP_HALF_US = 50;
  localparam int CLK_MHZ = 200;
  localparam int DRP_HALF_CYC = DRP_HALF_US * CLK_MHZ;
  // boot threshold for bus power conversion result
  localparam logic [7:0] BOOT_EXT_CODE = 8'h80;
endpackage

// ### src/tcpd_sync.sv
// two-flop synchroniser for a bus of front-end comparator levels
`timescale 1ns/10ps
module tcpd_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### src/tcpd_tick.sv
// free-running divider that gives a one-cycle enable every n cycles
`timescale 1ns/10ps
module tcpd_tick #(
  parameter int N = 10000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // enable pulse
  output logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_q == 16'(N - 1))
    begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ### testbench/tcpd_partner.sv
// behavioural port partner and cable seen through the cc and data-line comparators
`timescale 1ns/10ps
module tcpd_partner (
  // far side setup per pin: 0 open, 1 sink pull-down, 2 cable, 3 source pull-up
  input wire logic [1:0] kind0,
  input wire logic [1:0] kind1,
  input wire logic [1:0] src_adv,
  input wire logic swap_drop,
  input wire logic vb_off,
  input wire logic dp_hi,
  // device front-end controls
  input wire logic [1:0] cc_pullup_current,
  input wire logic vbus_src_en,
  input wire logic [1:0] swap_signal_pulldown,
  // comparator levels back to the device
  output logic [1:0] cc_below_sink,
  output logic [1:0] cc_below_cable,
  output logic [1:0] cc_below_swap,
  output logic [1:0] cc_above_1p5,
  output logic [1:0] cc_above_3p0,
  output logic vbus_present,
  output logic dplus_above_0p6
);
  logic [1:0] k [2];
  always_comb
  begin
    k[0] = kind0;
    k[1] = kind1;
    for (int i = 0; i < 2; i++)
    begin
      // with no pull-up from the device an open pin sits at ground, only a source lifts it
      cc_below_sink[i] = cc_pullup_current[i] ? (k[i] == 2'h1 || k[i] == 2'h2) : (k[i] != 2'h3 || swap_drop);
      cc_below_cable[i] = cc_pullup_current[i] && k[i] == 2'h2;
      cc_below_swap[i] = k[i] == 2'h3 && swap_drop;
      cc_above_1p5[i] = !cc_pullup_current[i] && k[i] == 2'h3 && src_adv >= 2'h2;
      cc_above_3p0[i] = !cc_pullup_current[i] && k[i] == 2'h3 && src_adv == 2'h3;
    end
  end
  // vbus stays up through a swap: the partner sources as soon as it sees the swap pull-down
  assign vbus_present = !vb_off && (kind0 == 2'h3 || kind1 == 2'h3 || vbus_src_en || swap_signal_pulldown != 2'b00);
  assign dplus_above_0p6 = dp_hi;
endmodule

// ### testbench/tcpd_port_tb.sv
// self-checking bench for the type-c port detect and charger advert block
`timescale 1ns/10ps
module tcpd_port_tb;
  // arbitrary identity value
  localparam logic [31:0] ID_VAL = 32'h0000_0c3e;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er, vbus_present, swap_drop, vb_off, dp_hi, dp_cmp;
  logic dsamp, boot_valid, db, vbus_en, swap_ev, path_a, path_b, dsc, dmp, dshort, ddiv, csamp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [1:0] kind0, kind1, src_adv, b_snk, b_cab, b_swp, a_1p5, a_3p0, pu, adv_lvl, pd, sw_pd, vconn, vsrc, csnk, prev;
  logic [7:0] boot_code, m8;
  int err_total, total_checks, cyc_n, n;

  tcpd_port #(.DRP_HALF(8), .BLOCK_ID(ID_VAL)) u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cc_below_sink(b_snk), .cc_below_cable(b_cab), .cc_below_swap(b_swp), .cc_above_1p5(a_1p5),
    .cc_above_3p0(a_3p0), .vbus_present(vbus_present), .dplus_above_0p6(dp_cmp), .dline_sample_hi(dsamp),
    .boot_code(boot_code), .boot_code_valid(boot_valid), .cc_pullup_current(pu), .adv_level(adv_lvl),
    .trimmed_sink_pulldown(pd), .dead_battery_pulldown(db), .swap_signal_pulldown(sw_pd), .vbus_src_en(vbus_en),
    .vconn_en(vconn), .swap_event(swap_ev), .ext_path_ctrl_a(path_a), .ext_path_ctrl_b(path_b),
    .dplus_source_current(dsc), .dminus_pulldown(dmp), .data_line_voltage_source(vsrc),
    .data_line_current_sink(csnk), .data_short_resistor(dshort), .divider_drive(ddiv), .converter_sample(csamp));

  tcpd_partner u_partner (.kind0(kind0), .kind1(kind1), .src_adv(src_adv), .swap_drop(swap_drop), .vb_off(vb_off),
    .dp_hi(dp_hi), .cc_pullup_current(pu), .vbus_src_en(vbus_en), .swap_signal_pulldown(sw_pd),
    .cc_below_sink(b_snk), .cc_below_cable(b_cab),
    .cc_below_swap(b_swp), .cc_above_1p5(a_1p5), .cc_above_3p0(a_3p0), .vbus_present(vbus_present),
    .dplus_above_0p6(dp_cmp));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // {d+ source, d- pull-down, voltage source[1:0], current sink[1:0], short, divider}
  function automatic logic [7:0] bc_exp(input int m);
    case (m)
      1: return 8'hc0;
      2: return 8'h18;
      3: return 8'h24;
      5: return 8'h02;
      6: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  task summarize;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && k < 50)
    begin
      k++;
      @(posedge mclk);
    end
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd & m);
  endtask

  task do_reset;
    rst <= 1'b1;
    cyc(16);
    rst <= 1'b0;
  endtask

  always @(posedge mclk)
  begin
    cyc_n++;
    if (cyc_n == 30000)
    begin
      err_total++;
      $display("ERROR timeout expected done seen hang");
      summarize;
    end
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, swap_drop, vb_off, dp_hi, boot_valid, boot_code} = '0;
    {kind0, kind1, src_adv} = '0;
    seed = 32'h0000_4fad;
    dsamp = seed[3];
    rst = 1'b1;
    do_reset;
    rchk("ctrl rst", tcpd_pkg::OFF_CTRL, 32'hffff_ffff, tcpd_pkg::CTRL_RST);
    rchk("bc rst", tcpd_pkg::OFF_BC, 32'hffff_ffff, tcpd_pkg::BC_RST);
    rchk("id", tcpd_pkg::OFF_ID, 32'hffff_ffff, ID_VAL);
    rchk("dline", tcpd_pkg::OFF_STAT, 32'h0000_0800, {20'h0, dsamp, 11'h0});
    apb(12'h0f0, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    chk("db pulldown", 32'h1, {31'h0, db});
    seed = nxt(seed);
    boot_code <= seed[7:0] | 8'h80;
    boot_valid <= 1'b1;
    cyc(1);
    boot_valid <= 1'b0;
    boot_code <= 8'h00;
    cyc(3);
    rchk("boot", tcpd_pkg::OFF_BOOT, 32'h0000_01ff, {23'h0, 1'b1, seed[7:0] | 8'h80});
    boot_valid <= 1'b1;
    cyc(1);
    boot_valid <= 1'b0;
    rchk("boot held", tcpd_pkg::OFF_BOOT, 32'h0000_01ff, {23'h0, 1'b1, seed[7:0] | 8'h80});
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0103);
    cyc(4);
    chk("path a", 32'h2, {30'h0, path_a, path_b});
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0003);
    cyc(4);
    chk("path b", 32'h1, {30'h0, path_a, path_b});
    for (int lv = 0; lv < 4; lv++)
    begin
      apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'(lv << 2));
      cyc(4);
      chk("pullup", 32'h3, {30'h0, pu});
      chk("adv", 32'(lv), {30'h0, adv_lvl});
      chk("power open", 32'h0, {29'h0, vconn, vbus_en});
    end
    seed = nxt(seed);
    apb(tcpd_pkg::OFF_CTRL, 1'b1, {28'h0, seed[1:0], 2'h0});
    kind0 <= 2'h1;
    cyc(2);
    chk("sync delay", 32'h0, {31'h0, vbus_en});
    cyc(6);
    chk("attach", 32'h1, {29'h0, vconn, vbus_en});
    rchk("stat src", tcpd_pkg::OFF_STAT, 32'h0000_001f, 32'h0000_0009);
    kind0 <= 2'h0;
    cyc(6);
    chk("detach", 32'h0, {31'h0, vbus_en});
    rchk("evt detach", tcpd_pkg::OFF_EVT, 32'h0000_0001, 32'h0000_0001);
    apb(tcpd_pkg::OFF_EVT, 1'b1, 32'h0000_0001);
    rchk("evt clear", tcpd_pkg::OFF_EVT, 32'h0000_0001, 32'h0000_0000);
    kind0 <= 2'h1;
    kind1 <= 2'h2;
    cyc(8);
    chk("cable vconn", 32'h5, {29'h0, vconn, vbus_en});
    rchk("stat cable", tcpd_pkg::OFF_STAT, 32'h0000_007f, 32'h0000_0049);
    apb(tcpd_pkg::OFF_CTRL, 1'b1, {26'h0, 2'h3, seed[1:0], 2'h0});
    for (n = 0; n < 100 && sw_pd !== 2'h1; n++)
      @(posedge mclk);
    chk("swap pd", 32'h1, {30'h0, sw_pd});
    kind0 <= 2'h3;
    for (n = 0; n < 200 && vbus_en !== 1'b0; n++)
      @(posedge mclk);
    cyc(6);
    chk("swap to sink", 32'h1, {30'h0, vbus_en, pd[0]});
    rchk("req clear", tcpd_pkg::OFF_CTRL, 32'h0000_0020, 32'h0);
    vb_off <= 1'b1;
    kind1 <= 2'h0;
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0041);
    cyc(6);
    chk("snk pd", 32'h3, {30'h0, pd});
    chk("db early release", 32'h0, {31'h0, db});
    rchk("snk wait", tcpd_pkg::OFF_STAT, 32'h0000_0007, 32'h0000_0002);
    vb_off <= 1'b0;
    for (int a = 0; a < 4; a++)
    begin
      src_adv <= 2'(a);
      cyc(6);
      rchk("snk att", tcpd_pkg::OFF_STAT, 32'h0000_0187, 32'(((a < 2 ? 0 : a) << 7) | 3));
    end
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0011);
    swap_drop <= 1'b1;
    for (n = 0; n < 50 && swap_ev !== 1'b1; n++)
      @(posedge mclk);
    chk("swap event", 32'h1, {31'h0, swap_ev});
    swap_drop <= 1'b0;
    kind0 <= 2'h1;
    rchk("evt swap", tcpd_pkg::OFF_EVT, 32'h0000_0002, 32'h0000_0002);
    for (n = 0; n < 200 && vbus_en !== 1'b1; n++)
      @(posedge mclk);
    cyc(2);
    chk("swap to src", 32'h4, {29'h0, vbus_en, pd});
    kind0 <= 2'h0;
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0002);
    n = 0;
    prev = pu;
    repeat (64)
    begin
      @(posedge mclk);
      n = n + ((pu !== prev) ? 1 : 0);
      prev = pu;
    end
    chk("drp toggles", 32'h1, {31'h0, n >= 4});
    chk("drp exclusive", 32'h0, {30'h0, pu & pd});
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0043);
    cyc(4);
    chk("db release", 32'h0, {31'h0, db});
    do_reset;
    cyc(2);
    chk("db again", 32'h1, {31'h0, db});
    apb(tcpd_pkg::OFF_CTRL, 1'b1, 32'h0000_0083);
    cyc(4);
    chk("db trimmed", 32'h0, {31'h0, db});
    for (int m = 0; m < 7; m++)
    begin
      apb(tcpd_pkg::OFF_BC, 1'b1, 32'(m));
      cyc(4);
      // the current sink in the mirror mode is masked out and never checked; the mirror check below covers only the d- voltage source
      m8 = (m == 4) ? 8'hf3 : 8'hff;
      chk("bc outputs", {24'h0, bc_exp(m) & m8}, {24'h0, {dsc, dmp, vsrc, csnk, dshort, ddiv} & m8});
      chk("bc sample", {31'h0, m == 2 || m == 3 || m == 4}, {31'h0, csamp});
    end
    apb(tcpd_pkg::OFF_BC, 1'b1, 32'h0000_0004);
    dp_hi <= 1'b1;
    cyc(6);
    chk("cdp mirror", 32'h1, {31'h0, vsrc[1]});
    rchk("stat mirror", tcpd_pkg::OFF_STAT, 32'h0000_0200, 32'h0000_0200);
    dp_hi <= 1'b0;
    cyc(6);
    chk("cdp release", 32'h0, {31'h0, vsrc[1]});
    summarize;
  end
endmodule
